// ==== periodic_timer_pkg.sv ====
// Package for the 10-bit periodic timer: register offsets, field layouts,
// mode and clock-select codes, reset values and the state carrier struct.
// Assumes an 8-bit register port with byte-wide registers at small offsets.
package periodic_timer_pkg;

    // Register offsets on the 4-bit register address.
    localparam logic [3:0] ADDR_CONTROL_0 = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_1 = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
    localparam logic [3:0] ADDR_COMPARE_A_LOW = 4'h4;
    localparam logic [3:0] ADDR_COMPARE_A_HIGH = 4'h5;
    localparam logic [3:0] ADDR_COMPARE_P_LOW = 4'h6;
    localparam logic [3:0] ADDR_COMPARE_P_HIGH = 4'h7;
    localparam logic [3:0] ADDR_MATCH_FLAGS = 4'h8;

    // Bit positions inside the match flag register (write one to clear).
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;

    // Operating mode codes of the two-bit mode field.
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_UNDEFINED = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;

    // Pin function codes; their meaning depends on the mode.
    localparam logic [1:0] PIN_FN_00 = 2'h0;
    localparam logic [1:0] PIN_FN_01 = 2'h1;
    localparam logic [1:0] PIN_FN_10 = 2'h2;
    localparam logic [1:0] PIN_FN_11 = 2'h3;

    // Clock select codes.
    localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CLK_SYS = 3'h1;
    localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
    localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
    localparam logic [2:0] CLK_SUB_A = 3'h4;
    localparam logic [2:0] CLK_SUB_B = 3'h5;
    localparam logic [2:0] CLK_EXT_RISE = 3'h6;
    localparam logic [2:0] CLK_EXT_FALL = 3'h7;

    // Prescaler terminal values for the divided internal clocks.
    localparam logic [5:0] DIV4_LAST = 6'h03;
    localparam logic [5:0] DIV16_LAST = 6'h0f;
    localparam logic [5:0] DIV64_LAST = 6'h3f;

    // Counter limits and reset values.
    localparam logic [9:0] COUNT_MAX = 10'h3ff;
    localparam logic [9:0] COUNT_ZERO = 10'h000;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Control register 0 layout, bit 7 down to bit 3.
    typedef struct packed {
        logic pause;
        logic [2:0] clk_sel;
        logic on;
    } control_0_s;

    // Control register 1 layout, bit 7 down to bit 0.
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] pin_fn;
        logic init_lvl;
        logic invert;
        logic spare;
        logic clr_sel;
    } control_1_s;

    // Complete state of the timer block.
    typedef struct packed {
        control_0_s c0;
        control_1_s c1;
        logic [9:0] cmp_a;
        logic [9:0] cmp_p;
        logic [9:0] count;
        logic on_prev;
        logic pin_lvl;
        logic flag_a;
        logic flag_p;
        logic [5:0] div;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic sub_s1;
        logic sub_s2;
        logic sub_s3;
        logic [7:0] rdata;
        logic out;
    } state_s;

endpackage

// ==== periodic_timer.sv ====
// Top module of the 10-bit periodic timer with comparators A and P.
// Assumes a bus master that drives one-cycle strobes on i_clock and
// asynchronous external and sub clock pins, which are synchronised here.
//
// Functional notes
// - Ten-bit up-counter from internal or pin clock.
// - Comparators A and P compare all counter bits.
// - Software only clears counter, via counter_on rise.
// - Overflow or selected match clears counter, raises flag.
// - Pause bit freezes counter; clearing resumes counting.
// - Clock select picks system, divided, sub or pin-edge clock.
// - Counter_on runs counter; rise clears to zero.
// - Counter_on rise restores output initial level.
// - Mode field selects compare, PWM or timer.
// - Timer mode ignores pin function, output unused.
// - Compare mode A match: none, low, high, toggle.
// - PWM mode: inactive, active, PWM, single pulse.
// - Requested level equal initial gives no change.
// - Control 0 bits 2 to 0 read zero.
// - Counter read-only pair; compare pairs read-write.
// - Clear source picks A match or P/overflow.
// - Invert bit flips output, except timer and undefined modes.
// - Initial level bit sets start or active level.
// - A-clear in compare mode never sets P flag.
`timescale 1ns/1ns

module periodic_timer (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ext_clock_pin,
    input wire logic i_sub_clock,
    output logic [7:0] o_rdata,
    output logic o_timer_output_pin,
    output logic o_match_a_flag,
    output logic o_match_p_flag
);

    // Registered state and its next value.
    periodic_timer_pkg::state_s st_r;
    periodic_timer_pkg::state_s st_nxt;

    // Decoded mode conditions of the current state.
    logic is_sp; // Single pulse sub-mode.
    logic is_pwm; // PWM waveform or forced level sub-mode.
    logic is_cmp; // Compare match output mode.
    logic cmp_like; // Compare, timer or undefined mode: same counting rules.
    logic on_rise; // Counter_on went from zero to one.
    logic ext_edge; // Selected active edge of the external pin.
    logic sub_edge; // Rising edge of the sub clock.
    logic tick; // One counting step this cycle.
    logic match_a; // Comparator A matched on this step.
    logic match_p; // Comparator P matched on this step.
    logic ovf; // Counter wraps from its maximum on this step.
    logic clear_cnt; // Counter returns to zero after this step.

    // Output level as a function of a state, so the registered output always
    // agrees with the registered state and needs no extra cycle of skew.
    function automatic logic out_of(input periodic_timer_pkg::state_s s);
        logic active;
        logic lvl;
        active = 1'b0;
        lvl = 1'b0;
        if (s.c1.mode == periodic_timer_pkg::MODE_COMPARE) begin
            lvl = s.pin_lvl ^ s.c1.invert;
        end else if (s.c1.mode == periodic_timer_pkg::MODE_PWM) begin
            unique case (s.c1.pin_fn)
                periodic_timer_pkg::PIN_FN_00: active = 1'b0;
                periodic_timer_pkg::PIN_FN_01: active = 1'b1;
                periodic_timer_pkg::PIN_FN_10: active = (s.count < s.cmp_a);
                periodic_timer_pkg::PIN_FN_11: active = s.c0.on;
            endcase
            // Active level follows the initial level bit.
            lvl = (active ? s.c1.init_lvl : ~s.c1.init_lvl) ^ s.c1.invert;
        end else begin
            // Timer and undefined modes leave the pin unused and parked low.
            lvl = 1'b0;
        end
        return lvl;
    endfunction

    // Mode decode; the undefined code counts like timer mode.
    always_comb begin
        is_sp = (st_r.c1.mode == periodic_timer_pkg::MODE_PWM) &&
                (st_r.c1.pin_fn == periodic_timer_pkg::PIN_FN_11);
        is_pwm = (st_r.c1.mode == periodic_timer_pkg::MODE_PWM) && !is_sp;
        is_cmp = (st_r.c1.mode == periodic_timer_pkg::MODE_COMPARE);
        cmp_like = (st_r.c1.mode != periodic_timer_pkg::MODE_PWM);
        on_rise = st_r.c0.on && !st_r.on_prev;
    end

    // Clock source selection; only the second and third sync stages are read.
    always_comb begin
        sub_edge = st_r.sub_s2 && !st_r.sub_s3;
        if (st_r.c0.clk_sel == periodic_timer_pkg::CLK_EXT_FALL) begin
            ext_edge = !st_r.ext_s2 && st_r.ext_s3;
        end else begin
            ext_edge = st_r.ext_s2 && !st_r.ext_s3;
        end
        unique case (st_r.c0.clk_sel)
            periodic_timer_pkg::CLK_SYS_DIV4: tick = (st_r.div[1:0] == periodic_timer_pkg::DIV4_LAST[1:0]);
            periodic_timer_pkg::CLK_SYS: tick = 1'b1;
            periodic_timer_pkg::CLK_HIGH_DIV16: tick = (st_r.div[3:0] == periodic_timer_pkg::DIV16_LAST[3:0]);
            periodic_timer_pkg::CLK_HIGH_DIV64: tick = (st_r.div == periodic_timer_pkg::DIV64_LAST);
            periodic_timer_pkg::CLK_SUB_A: tick = sub_edge;
            periodic_timer_pkg::CLK_SUB_B: tick = sub_edge;
            periodic_timer_pkg::CLK_EXT_RISE: tick = ext_edge;
            periodic_timer_pkg::CLK_EXT_FALL: tick = ext_edge;
        endcase
        // Counting needs the timer on, not paused, and not in the clearing cycle.
        tick = tick && st_r.c0.on && !st_r.c0.pause && !on_rise;
    end

    // Comparator events; a zero A value never matches.
    always_comb begin
        match_a = tick && (st_r.cmp_a != periodic_timer_pkg::COUNT_ZERO) &&
                  (st_r.count == st_r.cmp_a);
        match_p = tick && (st_r.cmp_p != periodic_timer_pkg::COUNT_ZERO) &&
                  (st_r.count == st_r.cmp_p);
        ovf = tick && (st_r.count == periodic_timer_pkg::COUNT_MAX);
        if (is_sp) begin
            // Single pulse only restarts the counter on a counter_on rise.
            clear_cnt = 1'b0;
        end else if (cmp_like && st_r.c1.clr_sel) begin
            clear_cnt = match_a;
        end else begin
            clear_cnt = match_p || (ovf && st_r.cmp_p == periodic_timer_pkg::COUNT_ZERO);
        end
    end

    // Next-state logic: bus writes, counter, flags, pin level and read data.
    always_comb begin
        st_nxt = st_r;
        // Synchronisers: the first stage feeds only the second.
        st_nxt.ext_s1 = i_ext_clock_pin;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;
        st_nxt.sub_s1 = i_sub_clock;
        st_nxt.sub_s2 = st_r.sub_s1;
        st_nxt.sub_s3 = st_r.sub_s2;
        st_nxt.div = st_r.div + 6'h01;
        st_nxt.on_prev = st_r.c0.on;

        // Counter: no register write reaches it; only clears and steps.
        if (on_rise) begin
            st_nxt.count = periodic_timer_pkg::COUNT_ZERO;
        end else if (clear_cnt) begin
            st_nxt.count = periodic_timer_pkg::COUNT_ZERO;
        end else if (tick) begin
            st_nxt.count = st_r.count + 10'h001;
        end

        // Single pulse: A match ends the pulse by clearing counter_on, and an
        // external active edge starts one by setting it.
        if (is_sp && match_a) begin
            st_nxt.c0.on = 1'b0;
        end
        if (is_sp && ext_edge && !st_r.c0.on) begin
            st_nxt.c0.on = 1'b1;
        end

        // Pin level for compare mode; reset to the initial level on a rise.
        if (on_rise && st_r.c1.mode != periodic_timer_pkg::MODE_TIMER) begin
            st_nxt.pin_lvl = st_r.c1.init_lvl;
        end else if (is_cmp && match_a) begin
            // Driving the level it already has leaves the pin unchanged.
            unique case (st_r.c1.pin_fn)
                periodic_timer_pkg::PIN_FN_00: st_nxt.pin_lvl = st_r.pin_lvl;
                periodic_timer_pkg::PIN_FN_01: st_nxt.pin_lvl = 1'b0;
                periodic_timer_pkg::PIN_FN_10: st_nxt.pin_lvl = 1'b1;
                periodic_timer_pkg::PIN_FN_11: st_nxt.pin_lvl = ~st_r.pin_lvl;
            endcase
        end

        // Register writes; a software write of control 0 follows the hardware
        // updates above, so software has the last word on counter_on.
        if (i_wr) begin
            unique case (i_addr)
                periodic_timer_pkg::ADDR_CONTROL_0: st_nxt.c0 = i_wdata[7:3];
                periodic_timer_pkg::ADDR_CONTROL_1: st_nxt.c1 = i_wdata;
                periodic_timer_pkg::ADDR_COMPARE_A_LOW: st_nxt.cmp_a[7:0] = i_wdata;
                periodic_timer_pkg::ADDR_COMPARE_A_HIGH: st_nxt.cmp_a[9:8] = i_wdata[1:0];
                periodic_timer_pkg::ADDR_COMPARE_P_LOW: st_nxt.cmp_p[7:0] = i_wdata;
                periodic_timer_pkg::ADDR_COMPARE_P_HIGH: st_nxt.cmp_p[9:8] = i_wdata[1:0];
                periodic_timer_pkg::ADDR_MATCH_FLAGS: begin
                    // Write one to clear; a set in the same cycle wins below.
                    if (i_wdata[periodic_timer_pkg::FLAG_A_BIT]) begin
                        st_nxt.flag_a = 1'b0;
                    end
                    if (i_wdata[periodic_timer_pkg::FLAG_P_BIT]) begin
                        st_nxt.flag_p = 1'b0;
                    end
                end
                default: st_nxt.c0 = st_r.c0; // Counter and unmapped offsets store nothing; the write holds control 0 at its old value.
            endcase
        end

        // Flags are sticky; hardware set beats a software clear.
        if (match_a) begin
            st_nxt.flag_a = 1'b1;
        end
        if (!is_sp && !(cmp_like && st_r.c1.clr_sel) &&
            (match_p || (ovf && st_r.cmp_p == periodic_timer_pkg::COUNT_ZERO))) begin
            st_nxt.flag_p = 1'b1;
        end

        // Read data stands only in the cycle after the read strobe.
        st_nxt.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                periodic_timer_pkg::ADDR_CONTROL_0: st_nxt.rdata = {st_r.c0, 3'h0};
                periodic_timer_pkg::ADDR_CONTROL_1: st_nxt.rdata = st_r.c1;
                periodic_timer_pkg::ADDR_COUNT_LOW: st_nxt.rdata = st_r.count[7:0];
                periodic_timer_pkg::ADDR_COUNT_HIGH: st_nxt.rdata = {6'h00, st_r.count[9:8]};
                periodic_timer_pkg::ADDR_COMPARE_A_LOW: st_nxt.rdata = st_r.cmp_a[7:0];
                periodic_timer_pkg::ADDR_COMPARE_A_HIGH: st_nxt.rdata = {6'h00, st_r.cmp_a[9:8]};
                periodic_timer_pkg::ADDR_COMPARE_P_LOW: st_nxt.rdata = st_r.cmp_p[7:0];
                periodic_timer_pkg::ADDR_COMPARE_P_HIGH: st_nxt.rdata = {6'h00, st_r.cmp_p[9:8]};
                periodic_timer_pkg::ADDR_MATCH_FLAGS: st_nxt.rdata = {6'h00, st_r.flag_p, st_r.flag_a};
                default: st_nxt.rdata = 8'h00; // Unmapped offsets read as zero.
            endcase
        end

        // The output flip-flop mirrors the output function of the next state.
        st_nxt.out = out_of(st_nxt);
    end

    // State register; reset loads constants only.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flip-flops.
    assign o_rdata = st_r.rdata;
    assign o_timer_output_pin = st_r.out;
    assign o_match_a_flag = st_r.flag_a;
    assign o_match_p_flag = st_r.flag_p;

    // Checks on the counter, flags and pin, all in the single clock domain.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    on_rise_clear_a: assert property (on_rise |=> st_r.count == 10'h000)
        else $error("counter not cleared after counter_on rise");
    pause_hold_a: assert property (st_r.c0.pause && !on_rise |=> $stable(st_r.count))
        else $error("counter moved while paused");
    off_hold_a: assert property (!st_r.c0.on |=> $stable(st_r.count))
        else $error("counter moved while off");
    a_clear_a: assert property (match_a && cmp_like && st_r.c1.clr_sel |=> st_r.count == 10'h000)
        else $error("comparator A match did not clear counter");
    flag_sticky_a: assert property (st_r.flag_a && !(i_wr && i_addr == 4'h8 && i_wdata[0])
        |=> st_r.flag_a)
        else $error("match A flag dropped without clear");
    no_p_flag_a: assert property (is_cmp && st_r.c1.clr_sel && !st_r.flag_p |=> !st_r.flag_p)
        else $error("P flag set with A clear source");
    toggle_pin_a: assert property (is_cmp && match_a && !on_rise && st_r.c1.pin_fn == 2'h3
        |=> st_r.pin_lvl != $past(st_r.pin_lvl))
        else $error("toggle on A match missing");
    init_level_a: assert property (on_rise && st_r.c1.mode != 2'h3
        |=> st_r.pin_lvl == $past(st_r.c1.init_lvl))
        else $error("pin not restored to initial level");
    cmp_invert_a: assert property (is_cmp |-> o_timer_output_pin == (st_r.pin_lvl ^ st_r.c1.invert))
        else $error("compare output ignores invert bit");
    timer_pin_a: assert property (st_r.c1.mode == 2'h3 |-> !o_timer_output_pin)
        else $error("timer mode drives output pin");
    ctrl0_zero_a: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[2:0] == 3'h0)
        else $error("control 0 low bits not zero");
    pulse_end_a: assert property (is_sp && match_a && !i_wr |=> !st_r.c0.on)
        else $error("single pulse did not end on A match");

    toggle_seen_c: cover property (is_cmp && match_a && st_r.c1.pin_fn == 2'h3);
    overflow_seen_c: cover property (ovf && st_r.cmp_p == 10'h000);
    pulse_seen_c: cover property (is_sp && match_a);
    pause_seen_c: cover property (st_r.c0.on && st_r.c0.pause ##4 !st_r.c0.pause);

endmodule // periodic_timer

// ==== clock_pin_source.sv ====
// Far-side model of the timer: the external clock pin and the sub clock.
// Assumes one bench process at a time calls send_pulses.
`timescale 1ns/1ns

module clock_pin_source (
    input wire logic i_clock,
    output logic o_ext_clock_pin,
    output logic o_sub_clock
);
    // Both lines rest low between bursts, so only the edges that were asked for reach the timer.
    initial begin
        o_ext_clock_pin = 1'b0;
        o_sub_clock = 1'b0;
    end

    // Sends n whole pulses on one line.
    // Hold sets the clocks per level, so fast and slow sources both occur.
    task automatic send_pulses(input bit sub, input int n, input int hold);
        repeat (n) begin
            @(posedge i_clock);
            if (sub) begin
                o_sub_clock <= 1'b1;
            end else begin
                o_ext_clock_pin <= 1'b1;
            end
            repeat (hold) @(posedge i_clock);
            o_sub_clock <= 1'b0;
            o_ext_clock_pin <= 1'b0;
            repeat (hold) @(posedge i_clock);
        end
    endtask
endmodule // clock_pin_source

// ==== periodic_timer_test.sv ====
// Self-checking bench for the periodic timer with an integer model.
// Assumes the one-cycle register port and the note's tick latencies.
`timescale 1ns/1ns

module periodic_timer_test;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    wire logic ext_pin; // Driven by the far-side model.
    wire logic sub_pin;
    logic [7:0] rdata;
    logic pin_out;
    logic flag_a;
    logic flag_p;
    logic [7:0] rd_val;
    logic [9:0] cnt_val;
    int miscompares = 0;
    int num_checks = 0;
    int seed = 56445;
    // Model state and the configuration of the current case.
    int m_cnt, m_fa, m_fp, m_pin, c_mode, c_fn, c_init, c_inv, c_clr, c_a, c_p;
    int divs[4] = '{4, 1, 16, 64};

    // A 40 ns clock for the 25 MHz system clock.
    always #20 i_clock = ~i_clock;

    periodic_timer periodic_timer_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_clock_pin(ext_pin),
        .i_sub_clock(sub_pin), .o_rdata(rdata), .o_timer_output_pin(pin_out),
        .o_match_a_flag(flag_a), .o_match_p_flag(flag_p));
    clock_pin_source clock_pin_source_inst (.i_clock(i_clock), .o_ext_clock_pin(ext_pin),
        .o_sub_clock(sub_pin));

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Case equality, so an unknown never passes for a match.
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe, released at the edge that samples it.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic rd(input logic [3:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        rd_val = rdata;
    endtask

    // Reads the counter pair; the high byte's bits 7:2 must be zero.
    task automatic rd_count();
        rd(periodic_timer_pkg::ADDR_COUNT_LOW);
        cnt_val[7:0] = rd_val;
        rd(periodic_timer_pkg::ADDR_COUNT_HIGH);
        cnt_val[9:8] = rd_val[1:0];
        chk({4'h0, rd_val[7:2]}, 10'h000, "count high spare");
    endtask

    // Advances the model by n counter ticks.
    task automatic model_ticks(input int n);
        int ma, mp, wrap;
        repeat (n) begin
            ma = (m_cnt == c_a) && (c_a != 0);
            mp = (m_cnt == c_p) && (c_p != 0);
            wrap = (m_cnt == 1023) && (c_p == 0);
            if (ma) m_fa = 1;
            if (!c_clr && (mp || wrap)) m_fp = 1;
            if (ma && c_mode == 0 && c_fn != 0) m_pin = (c_fn == 3) ? !m_pin : c_fn - 1;
            m_cnt = (c_clr ? ma : (mp || wrap)) ? 0 : (m_cnt + 1) % 1024;
        end
    endtask

    // Expected pin level; timer and undefined modes leave the pin low.
    function automatic logic exp_pin();
        if (c_mode == 0) return m_pin[0] ^ c_inv[0];
        if (c_mode != 2) return 1'b0;
        if (c_fn == 2) return (m_cnt < c_a) ? c_init[0] : !c_init[0];
        return (c_fn == 1) ? c_init[0] : !c_init[0];
    endfunction

    // Compares the frozen counter, both flags and the pin with the model.
    task automatic check_state();
        rd_count();
        chk(cnt_val, 10'(m_cnt), "count");
        chk(10'(flag_a), 10'(m_fa), "flag a");
        chk(10'(flag_p), 10'(m_fp), "flag p");
        chk(10'(pin_out), 10'(exp_pin()), "pin");
    endtask

    // Configures, runs n ticks at the system clock, pauses, resumes five ticks.
    task automatic run_case(input int mode, fn, init, inv, clr, a, p, n);
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h00);
        wr(periodic_timer_pkg::ADDR_CONTROL_1, {mode[1:0], fn[1:0], init[0], inv[0], 1'b0, clr[0]});
        wr(periodic_timer_pkg::ADDR_COMPARE_A_LOW, a[7:0]);
        wr(periodic_timer_pkg::ADDR_COMPARE_A_HIGH, {6'h00, a[9:8]});
        wr(periodic_timer_pkg::ADDR_COMPARE_P_LOW, p[7:0]);
        wr(periodic_timer_pkg::ADDR_COMPARE_P_HIGH, {6'h00, p[9:8]});
        wr(periodic_timer_pkg::ADDR_MATCH_FLAGS, 8'h03);
        {c_mode, c_fn, c_init, c_inv, c_clr, c_a, c_p} = {mode, fn, init, inv, clr, a, p};
        m_cnt = 0;
        m_fa = 0;
        m_fp = 0;
        m_pin = init;
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h18);
        repeat (n - 1) @(posedge i_clock);
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h98);
        model_ticks(n);
        check_state();
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h18);
        repeat (3) @(posedge i_clock);
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h98);
        model_ticks(5);
        check_state();
        wr(periodic_timer_pkg::ADDR_MATCH_FLAGS, 8'h01);
        @(negedge i_clock);
        chk(10'(flag_a), 10'h000, "flag a cleared");
        chk(10'(flag_p), 10'(m_fp), "flag p kept");
        $display("test mode %0d fn %0d done", mode, fn);
    endtask

    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge i_clock);
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge i_clock);
        i_nrst <= 1'b1;
        // Reset values, reserved bits, read-only counter and an unmapped place.
        for (int a = 0; a < 10; a++) begin
            rd(4'(a));
            chk({2'h0, rd_val}, 10'h000, "reset value");
        end
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'hff);
        rd(periodic_timer_pkg::ADDR_CONTROL_0);
        chk({2'h0, rd_val}, 10'h0f8, "control 0");
        wr(periodic_timer_pkg::ADDR_COMPARE_A_HIGH, 8'hff);
        rd(periodic_timer_pkg::ADDR_COMPARE_A_HIGH);
        chk({2'h0, rd_val}, 10'h003, "compare high");
        wr(periodic_timer_pkg::ADDR_COUNT_LOW, 8'hff);
        wr(4'h9, 8'hff);
        rd(periodic_timer_pkg::ADDR_COUNT_LOW);
        chk({2'h0, rd_val}, 10'h000, "count write");
        rd(4'h9);
        chk({2'h0, rd_val}, 10'h000, "unmapped");
        $display("test registers done");
        // Pin and pulse clock sources, fast and slow.
        run_case(3, 0, 0, 0, 0, 0, 0, 2);
        for (int c = 4; c < 8; c++) begin
            wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h00);
            wr(periodic_timer_pkg::ADDR_CONTROL_0, {1'b0, 3'(c), 4'h8});
            clock_pin_source_inst.send_pulses(c < 6, 5, (c % 2) ? 5 : 2);
            repeat (6) @(posedge i_clock);
            rd_count();
            chk(cnt_val, 10'h005, "pin clock count");
        end
        // System and divided clocks over a window of 256 system clocks.
        for (int c = 0; c < 4; c++) begin
            wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h00);
            wr(periodic_timer_pkg::ADDR_CONTROL_0, {1'b0, 3'(c), 4'h8});
            repeat (255) @(posedge i_clock);
            wr(periodic_timer_pkg::ADDR_CONTROL_0, {1'b1, 3'(c), 4'h8});
            rd_count();
            chk(cnt_val, 10'(256 / divs[c]), "divided count");
        end
        $display("test clock select done");
        run_case(0, 3, 0, 0, 1, 6, 2, 20);
        run_case(0, 1, 0, 0, 1, 4, 0, 9);
        run_case(0, 2, 1, 1, 0, 3, 7, 12);
        run_case(0, 0, 1, 0, 0, 2, 0, 1030);
        run_case(3, 3, 1, 1, 1, 3, 0, 8);
        for (int i = 0; i < 3; i++) begin
            run_case(2, i, 1, 0, 0, 4, 9, 6);
        end
        // Random configurations; PWM stays on its own clear and pin functions.
        repeat (8) begin
            c_mode = {$random(seed)} % 4;
            run_case(c_mode, {$random(seed)} % (c_mode == 2 ? 3 : 4), {$random(seed)} % 2,
                c_mode == 2 ? 0 : {$random(seed)} % 2, c_mode == 2 ? 0 : {$random(seed)} % 2,
                1 + {$random(seed)} % 12, {$random(seed)} % 12, 3 + {$random(seed)} % 40);
        end
        // Single pulse: the pulse is active while on, and an A match ends it by
        // clearing counter_on, so the counter stops one step past the A value.
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h00);
        wr(periodic_timer_pkg::ADDR_CONTROL_1, 8'hb8);
        wr(periodic_timer_pkg::ADDR_COMPARE_A_LOW, 8'h05);
        wr(periodic_timer_pkg::ADDR_COMPARE_A_HIGH, 8'h00);
        wr(periodic_timer_pkg::ADDR_MATCH_FLAGS, 8'h03);
        wr(periodic_timer_pkg::ADDR_CONTROL_0, 8'h18);
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        chk(10'(pin_out), 10'h001, "pulse active");
        repeat (10) @(posedge i_clock);
        rd(periodic_timer_pkg::ADDR_CONTROL_0);
        chk({2'h0, rd_val}, 10'h010, "pulse on cleared");
        rd_count();
        chk(cnt_val, 10'h006, "pulse count");
        chk(10'(flag_a), 10'h001, "pulse flag a");
        chk(10'(pin_out), 10'h000, "pulse ended");
        $display("test single pulse done");
        end_sim();
    end
endmodule // periodic_timer_test
